// ### pkg/pin_mux_pkg.sv
// Constants shared by the port pin function multiplexer
package pin_mux_pkg;

    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int NUM_PINS = 17;
    localparam int NUM_SIGS = 23;
    localparam int SIG_W = 5;
    localparam int CODE_W = 3;

    // ------------------------------------------------------------
    // Register byte offsets (Avalon-MM word aligned)
    // ------------------------------------------------------------
    localparam logic [7:0] MAP_P1_LOW_OFF = 8'h00;
    localparam logic [7:0] MAP_P1_HIGH_OFF = 8'h04;
    localparam logic [7:0] MAP_P1_EXT_OFF = 8'h08;
    localparam logic [7:0] MAP_P3_LOW_OFF = 8'h0c;
    localparam logic [7:0] MAP_P3_HIGH_OFF = 8'h10;
    localparam logic [7:0] MAP_P4_LOW_OFF = 8'h14;
    localparam logic [7:0] MAP_P4_HIGH_OFF = 8'h18;
    localparam logic [7:0] MAP_P4_EXT_OFF = 8'h1c;
    localparam logic [7:0] NO_OFF = 8'hff;
    // Per-port groups: port index 0..3 = port 1, 3, 4, A at base + 4 * index
    localparam logic [7:0] DIR_BASE_OFF = 8'h20;
    localparam logic [7:0] DATA_BASE_OFF = 8'h30;
    localparam logic [7:0] PULLUP_BASE_OFF = 8'h40;
    localparam logic [7:0] DRIVE_BASE_OFF = 8'h50;
    localparam logic [7:0] INPUT_BASE_OFF = 8'h60;
    localparam logic [7:0] CONFIG_OFF = 8'h70;

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int CFG_XTAL_BIT = 0;
    localparam int CFG_HWRST_BIT = 1;
    localparam logic [1:0] CONFIG_RESET = 2'h2;
    localparam logic [CODE_W-1:0] CODE_RESET = 3'h0;
    localparam logic [NUM_PINS-1:0] VEC_RESET = 17'h00000;
    localparam logic [31:0] WORD_RESET = 32'h00000000;
    // Pull-up exists on ports 1, 3, 4; drive switching on ports 1 and 3 only
    localparam logic [NUM_PINS-1:0] PULLUP_MASK = 17'h0ffff;
    localparam logic [NUM_PINS-1:0] DRIVE_MASK = 17'h00fff;
    // Pin indices of the crystal pins and the reset-shared bit
    localparam int XTAL_IN_PIN = 14;
    localparam int XTAL_OUT_PIN = 15;
    localparam int RST_SHARED_PIN = 16;

    // ------------------------------------------------------------
    // Peripheral signal indices; 0 means no peripheral
    // ------------------------------------------------------------
    localparam logic [SIG_W-1:0] SIG_NONE = 5'h00, SIG_TMRB_OUT = 5'h01, SIG_UART_TX = 5'h02;
    localparam logic [SIG_W-1:0] SIG_KEY0 = 5'h03, SIG_KEY1 = 5'h04, SIG_KEY2 = 5'h05;
    localparam logic [SIG_W-1:0] SIG_KEY3 = 5'h06, SIG_ADC_TRIG = 5'h07, SIG_TMRJ_OUT = 5'h08;
    localparam logic [SIG_W-1:0] SIG_TMRC_A = 5'h09, SIG_TMRC_B = 5'h0a, SIG_TMRC_C = 5'h0b;
    localparam logic [SIG_W-1:0] SIG_TMRC_D = 5'h0c, SIG_EXT0 = 5'h0d, SIG_EXT1 = 5'h0e;
    localparam logic [SIG_W-1:0] SIG_EXT2 = 5'h0f, SIG_EXT3 = 5'h10, SIG_UART_RX = 5'h11;
    localparam logic [SIG_W-1:0] SIG_CMP1_OUT = 5'h12, SIG_CMP3_OUT = 5'h13;
    localparam logic [SIG_W-1:0] SIG_TMRJ_IO = 5'h14, SIG_TMRC_CLK = 5'h15, SIG_UART_CLK = 5'h16;

    // ------------------------------------------------------------
    // Pin position helpers
    // ------------------------------------------------------------
    // Pins 0-7 port 1, 8-11 port 3 bits 3,4,5,7, 12-15 port 4 bits 2,5,6,7, 16 port A bit 0
    function automatic logic [1:0] pin_port(input logic [4:0] pin);
        if (pin < 5'd8) return 2'h0;
        else if (pin < 5'd12) return 2'h1;
        else if (pin < 5'd16) return 2'h2;
        else return 2'h3;
    endfunction

    function automatic logic [2:0] pin_bit(input logic [4:0] pin);
        case (pin)
            5'd8: return 3'h3;
            5'd9: return 3'h4;
            5'd10: return 3'h5;
            5'd11: return 3'h7;
            5'd12: return 3'h2;
            5'd13: return 3'h5;
            5'd14: return 3'h6;
            5'd15: return 3'h7;
            5'd16: return 3'h0;
            default: return pin[2:0];
        endcase
    endfunction

    function automatic logic [7:0] port_off(input logic [7:0] base, input logic [1:0] port);
        return 8'(base + {4'h0, port, 2'h0});
    endfunction

endpackage

// ### design/pin_input_sync.sv
// Two-stage synchroniser for the asynchronous pin levels
`timescale 1ns/1ps
`default_nettype none

module pin_input_sync #(
    parameter int WIDTH = 17
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic [WIDTH-1:0] d_in,
    output logic [WIDTH-1:0] q_out
);

    logic [WIDTH-1:0] meta_reg;

    // ------------------------------------------------------------
    // Synchroniser
    // ------------------------------------------------------------
    // First stage feeds only the second stage to keep metastability contained
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            meta_reg <= '0;
            q_out <= '0;
        end else begin
            meta_reg <= d_in;
            q_out <= meta_reg;
        end
    end

endmodule

`default_nettype wire

// ### design/port_pin_function_mux.sv
// Port pin function multiplexer with Avalon-MM register slave
//
// How it works
// - Seventeen port bits, each but the reset-shared bit shareable with peripherals
// - Pin driver and input follow selected function
// - Low, high and expansion mapping registers select function
// - Direction register bit sets plain port direction
// - Crystal pins free only without crystal oscillator
// - Reset-shared bit: no pull-up, no drive switching
// - Pull-up connects only while bit is input
// - Drive strength select on ports 1, 3 only
//
// Added by the designer: the register addresses and the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none

module port_pin_function_mux (
    input wire logic MCLK_IN,
    input wire logic SYS_RST_IN,
    input wire logic [7:0] AVS_ADDRESS_IN,
    input wire logic AVS_READ_IN,
    input wire logic AVS_WRITE_IN,
    input wire logic [31:0] AVS_WRITEDATA_IN,
    output logic [31:0] AVS_READDATA_OUT,
    output logic AVS_WAITREQUEST_OUT,
    input wire logic [16:0] PIN_IN,
    output logic [16:0] PIN_OUT,
    output logic [16:0] PIN_OE_OUT,
    output logic [16:0] PIN_PULLUP_OUT,
    output logic [16:0] PIN_DRIVE_HIGH_OUT,
    input wire logic [22:0] PERIPH_OUT_IN,
    input wire logic [22:0] PERIPH_OE_IN,
    output logic [22:0] PERIPH_PIN_OUT
);

    localparam int NP = pin_mux_pkg::NUM_PINS;
    localparam int NS = pin_mux_pkg::NUM_SIGS;

    // ------------------------------------------------------------
    // Fixed per-pin function table
    // ------------------------------------------------------------
    // Codes with no entry return no peripheral, so the pin stays a plain port
    function automatic logic [4:0] pin_sig(input logic [4:0] pin, input logic [2:0] code);
        case ({pin, code})
            {5'd0, 3'h1}: return pin_mux_pkg::SIG_TMRC_D;
            {5'd0, 3'h2}: return pin_mux_pkg::SIG_KEY0;
            {5'd1, 3'h1}: return pin_mux_pkg::SIG_TMRC_A;
            {5'd1, 3'h2}: return pin_mux_pkg::SIG_KEY1;
            {5'd2, 3'h1}: return pin_mux_pkg::SIG_TMRC_B;
            {5'd2, 3'h2}: return pin_mux_pkg::SIG_KEY2;
            {5'd3, 3'h1}: return pin_mux_pkg::SIG_TMRC_C;
            {5'd3, 3'h2}: return pin_mux_pkg::SIG_KEY3;
            {5'd3, 3'h3}: return pin_mux_pkg::SIG_TMRB_OUT;
            {5'd4, 3'h1}: return pin_mux_pkg::SIG_UART_TX;
            {5'd4, 3'h2}: return pin_mux_pkg::SIG_UART_RX;
            {5'd4, 3'h3}: return pin_mux_pkg::SIG_EXT0;
            {5'd4, 3'h4}: return pin_mux_pkg::SIG_TMRC_B;
            {5'd5, 3'h1}: return pin_mux_pkg::SIG_UART_RX;
            {5'd5, 3'h2}: return pin_mux_pkg::SIG_TMRJ_IO;
            {5'd5, 3'h3}: return pin_mux_pkg::SIG_EXT1;
            {5'd5, 3'h4}: return pin_mux_pkg::SIG_CMP1_OUT;
            {5'd6, 3'h1}: return pin_mux_pkg::SIG_UART_CLK;
            {5'd6, 3'h2}: return pin_mux_pkg::SIG_TMRJ_OUT;
            {5'd6, 3'h3}: return pin_mux_pkg::SIG_TMRC_B;
            {5'd7, 3'h1}: return pin_mux_pkg::SIG_EXT1;
            {5'd7, 3'h2}: return pin_mux_pkg::SIG_TMRJ_IO;
            {5'd7, 3'h3}: return pin_mux_pkg::SIG_TMRC_CLK;
            {5'd8, 3'h1}: return pin_mux_pkg::SIG_TMRC_CLK;
            {5'd8, 3'h2}: return pin_mux_pkg::SIG_EXT3;
            {5'd9, 3'h1}: return pin_mux_pkg::SIG_TMRC_C;
            {5'd9, 3'h2}: return pin_mux_pkg::SIG_EXT2;
            {5'd10, 3'h1}: return pin_mux_pkg::SIG_TMRC_D;
            {5'd10, 3'h2}: return pin_mux_pkg::SIG_KEY2;
            {5'd10, 3'h3}: return pin_mux_pkg::SIG_CMP3_OUT;
            {5'd11, 3'h1}: return pin_mux_pkg::SIG_ADC_TRIG;
            {5'd11, 3'h2}: return pin_mux_pkg::SIG_TMRJ_OUT;
            {5'd11, 3'h3}: return pin_mux_pkg::SIG_TMRC_D;
            {5'd12, 3'h1}: return pin_mux_pkg::SIG_TMRB_OUT;
            {5'd12, 3'h2}: return pin_mux_pkg::SIG_UART_TX;
            {5'd12, 3'h3}: return pin_mux_pkg::SIG_KEY3;
            {5'd13, 3'h1}: return pin_mux_pkg::SIG_EXT0;
            {5'd13, 3'h2}: return pin_mux_pkg::SIG_ADC_TRIG;
            {5'd14, 3'h1}: return pin_mux_pkg::SIG_UART_RX;
            {5'd14, 3'h2}: return pin_mux_pkg::SIG_UART_TX;
            {5'd14, 3'h3}: return pin_mux_pkg::SIG_EXT1;
            {5'd14, 3'h4}: return pin_mux_pkg::SIG_CMP1_OUT;
            {5'd14, 3'h5}: return pin_mux_pkg::SIG_TMRJ_IO;
            {5'd15, 3'h1}: return pin_mux_pkg::SIG_EXT2;
            default: return pin_mux_pkg::SIG_NONE;
        endcase
    endfunction

    // Offset of the low/high map register holding a pin, and its 2-bit slot
    function automatic logic [7:0] map_off(input logic [4:0] pin);
        case (pin[4:1])
            4'h0, 4'h1: return pin_mux_pkg::MAP_P1_LOW_OFF;
            4'h2, 4'h3: return pin_mux_pkg::MAP_P1_HIGH_OFF;
            4'h4: return pin_mux_pkg::MAP_P3_LOW_OFF;
            4'h5: return pin_mux_pkg::MAP_P3_HIGH_OFF;
            4'h6: return pin_mux_pkg::MAP_P4_LOW_OFF;
            4'h7: return pin_mux_pkg::MAP_P4_HIGH_OFF;
            default: return pin_mux_pkg::NO_OFF;
        endcase
    endfunction

    function automatic logic [1:0] map_slot(input logic [4:0] pin);
        return (pin < 5'd8) ? pin[1:0] : {1'b0, pin[0]};
    endfunction

    // Expansion register carrying the third select bit (pins 4, 5, 14)
    function automatic logic [7:0] ext_off(input logic [4:0] pin);
        case (pin)
            5'd4, 5'd5: return pin_mux_pkg::MAP_P1_EXT_OFF;
            5'd14: return pin_mux_pkg::MAP_P4_EXT_OFF;
            default: return pin_mux_pkg::NO_OFF;
        endcase
    endfunction

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [NP-1:0][2:0] code_reg, code_next;
    logic [NP-1:0] dir_reg, dir_next;
    logic [NP-1:0] dout_reg, dout_next;
    logic [NP-1:0] pull_reg, pull_next;
    logic [NP-1:0] drive_reg, drive_next;
    logic [1:0] cfg_reg, cfg_next;
    logic ack_reg;
    logic [31:0] rd_word;
    logic [NP-1:0] pin_sync;
    logic [NP-1:0][4:0] sig_w;
    logic [NP-1:0] routed_w, usable_w, out_w, oe_w, pull_w;
    logic [NS-1:0] periph_in_w;

    wire request_w = AVS_READ_IN | AVS_WRITE_IN;
    wire wr_fire_w = AVS_WRITE_IN & ack_reg;
    wire aligned_w = (AVS_ADDRESS_IN[1:0] == 2'h0);
    wire xtal_used_w = cfg_reg[pin_mux_pkg::CFG_XTAL_BIT];
    wire hwrst_used_w = cfg_reg[pin_mux_pkg::CFG_HWRST_BIT];

    pin_input_sync #(
        .WIDTH(NP)
    ) u_sync (
        .clk_in(MCLK_IN),
        .rst_in(SYS_RST_IN),
        .d_in(PIN_IN),
        .q_out(pin_sync)
    );

    // ------------------------------------------------------------
    // Per-pin routing
    // ------------------------------------------------------------
    for (genvar p = 0; p < NP; p++) begin : g_pin
        assign sig_w[p] = pin_sig(5'(p), code_reg[p]);
        assign routed_w[p] = (sig_w[p] != pin_mux_pkg::SIG_NONE);
        // Crystal pins belong to the oscillator, the reset bit to reset, when in use
        assign usable_w[p] = !(xtal_used_w && (p == pin_mux_pkg::XTAL_IN_PIN
            || p == pin_mux_pkg::XTAL_OUT_PIN))
            && !(hwrst_used_w && p == pin_mux_pkg::RST_SHARED_PIN);
        assign oe_w[p] = usable_w[p] && (routed_w[p] ? PERIPH_OE_IN[sig_w[p]] : dir_reg[p]);
        assign out_w[p] = usable_w[p] && (routed_w[p] ? PERIPH_OUT_IN[sig_w[p]] : dout_reg[p]);
        // Pull-up only when the pin is not driven from inside
        assign pull_w[p] = usable_w[p] && !oe_w[p] && pull_reg[p];
    end

    // Each peripheral input sees the synchronised level of a pin mapped to it
    always_comb begin
        periph_in_w = '0;
        for (int p = 0; p < NP; p++) begin
            if (routed_w[p] && usable_w[p]) begin
                periph_in_w[sig_w[p]] = pin_sync[p];
            end
        end
    end

    // ------------------------------------------------------------
    // Register write decode
    // ------------------------------------------------------------
    always_comb begin
        logic [1:0] port;
        logic [2:0] bpos;
        port = 2'h0;
        bpos = 3'h0;
        code_next = code_reg;
        dir_next = dir_reg;
        dout_next = dout_reg;
        pull_next = pull_reg;
        drive_next = drive_reg;
        cfg_next = cfg_reg;
        if (wr_fire_w && aligned_w) begin
            for (int p = 0; p < NP; p++) begin
                port = pin_mux_pkg::pin_port(5'(p));
                bpos = pin_mux_pkg::pin_bit(5'(p));
                if (AVS_ADDRESS_IN == map_off(5'(p))) begin
                    code_next[p][1:0] = AVS_WRITEDATA_IN[2*map_slot(5'(p)) +: 2];
                end
                if (AVS_ADDRESS_IN == ext_off(5'(p))) begin
                    code_next[p][2] = AVS_WRITEDATA_IN[map_slot(5'(p))];
                end
                if (AVS_ADDRESS_IN == pin_mux_pkg::port_off(pin_mux_pkg::DIR_BASE_OFF, port)) begin
                    dir_next[p] = AVS_WRITEDATA_IN[bpos];
                end
                if (AVS_ADDRESS_IN == pin_mux_pkg::port_off(pin_mux_pkg::DATA_BASE_OFF, port)) begin
                    dout_next[p] = AVS_WRITEDATA_IN[bpos];
                end
                if (AVS_ADDRESS_IN == pin_mux_pkg::port_off(pin_mux_pkg::PULLUP_BASE_OFF, port)) begin
                    pull_next[p] = AVS_WRITEDATA_IN[bpos] & pin_mux_pkg::PULLUP_MASK[p];
                end
                if (AVS_ADDRESS_IN == pin_mux_pkg::port_off(pin_mux_pkg::DRIVE_BASE_OFF, port)) begin
                    drive_next[p] = AVS_WRITEDATA_IN[bpos] & pin_mux_pkg::DRIVE_MASK[p];
                end
            end
            if (AVS_ADDRESS_IN == pin_mux_pkg::CONFIG_OFF) begin
                cfg_next = AVS_WRITEDATA_IN[1:0];
            end
        end
    end

    // ------------------------------------------------------------
    // Register read mux
    // ------------------------------------------------------------
    // Data registers read the pin for inputs and the latch for outputs
    always_comb begin
        logic [1:0] port;
        logic [2:0] bpos;
        port = 2'h0;
        bpos = 3'h0;
        rd_word = pin_mux_pkg::WORD_RESET;
        if (aligned_w) begin
            for (int p = 0; p < NP; p++) begin
                port = pin_mux_pkg::pin_port(5'(p));
                bpos = pin_mux_pkg::pin_bit(5'(p));
                if (AVS_ADDRESS_IN == map_off(5'(p))) begin
                    rd_word[2*map_slot(5'(p)) +: 2] = code_reg[p][1:0];
                end
                if (AVS_ADDRESS_IN == ext_off(5'(p))) begin
                    rd_word[map_slot(5'(p))] = code_reg[p][2];
                end
                if (AVS_ADDRESS_IN == pin_mux_pkg::port_off(pin_mux_pkg::DIR_BASE_OFF, port)) begin
                    rd_word[bpos] = dir_reg[p];
                end
                if (AVS_ADDRESS_IN == pin_mux_pkg::port_off(pin_mux_pkg::DATA_BASE_OFF, port)) begin
                    rd_word[bpos] = dir_reg[p] ? dout_reg[p] : pin_sync[p];
                end
                if (AVS_ADDRESS_IN == pin_mux_pkg::port_off(pin_mux_pkg::PULLUP_BASE_OFF, port)) begin
                    rd_word[bpos] = pull_reg[p];
                end
                if (AVS_ADDRESS_IN == pin_mux_pkg::port_off(pin_mux_pkg::DRIVE_BASE_OFF, port)) begin
                    rd_word[bpos] = drive_reg[p];
                end
                if (AVS_ADDRESS_IN == pin_mux_pkg::port_off(pin_mux_pkg::INPUT_BASE_OFF, port)) begin
                    rd_word[bpos] = pin_sync[p];
                end
            end
            if (AVS_ADDRESS_IN == pin_mux_pkg::CONFIG_OFF) begin
                rd_word[1:0] = cfg_reg;
            end
        end
    end

    // ------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------
    always_ff @(posedge MCLK_IN) begin
        if (SYS_RST_IN) begin
            code_reg <= {NP{pin_mux_pkg::CODE_RESET}};
            dir_reg <= pin_mux_pkg::VEC_RESET;
            dout_reg <= pin_mux_pkg::VEC_RESET;
            pull_reg <= pin_mux_pkg::VEC_RESET;
            drive_reg <= pin_mux_pkg::VEC_RESET;
            cfg_reg <= pin_mux_pkg::CONFIG_RESET;
        end else begin
            code_reg <= code_next;
            dir_reg <= dir_next;
            dout_reg <= dout_next;
            pull_reg <= pull_next;
            drive_reg <= drive_next;
            cfg_reg <= cfg_next;
        end
    end

    // ------------------------------------------------------------
    // Bus handshake
    // ------------------------------------------------------------
    // One wait cycle per access; costs a cycle but keeps every output registered
    always_ff @(posedge MCLK_IN) begin
        if (SYS_RST_IN) begin
            ack_reg <= 1'b0;
            AVS_WAITREQUEST_OUT <= 1'b1;
            AVS_READDATA_OUT <= pin_mux_pkg::WORD_RESET;
        end else begin
            ack_reg <= request_w & ~ack_reg;
            AVS_WAITREQUEST_OUT <= ~(request_w & ~ack_reg);
            if (AVS_READ_IN && !ack_reg) begin
                AVS_READDATA_OUT <= rd_word;
            end
        end
    end

    // ------------------------------------------------------------
    // Pin and peripheral outputs
    // ------------------------------------------------------------
    always_ff @(posedge MCLK_IN) begin
        if (SYS_RST_IN) begin
            PIN_OUT <= pin_mux_pkg::VEC_RESET;
            PIN_OE_OUT <= pin_mux_pkg::VEC_RESET;
            PIN_PULLUP_OUT <= pin_mux_pkg::VEC_RESET;
            PIN_DRIVE_HIGH_OUT <= pin_mux_pkg::VEC_RESET;
            PERIPH_PIN_OUT <= '0;
        end else begin
            PIN_OUT <= out_w;
            PIN_OE_OUT <= oe_w;
            PIN_PULLUP_OUT <= pull_w;
            PIN_DRIVE_HIGH_OUT <= drive_reg & pin_mux_pkg::DRIVE_MASK;
            PERIPH_PIN_OUT <= periph_in_w;
        end
    end

endmodule

`default_nettype wire

// ### verification/pad_board_model.sv
// Board and pad model that resolves each pin from the mux drive and the outside world
`timescale 1ns/1ps
`default_nettype none

module pad_board_model (
    input wire logic clk_in,
    input wire logic [16:0] drv_val_in,
    input wire logic [16:0] drv_oe_in,
    input wire logic [16:0] pull_in,
    input wire logic [16:0] ext_en_in,
    input wire logic [16:0] ext_val_in,
    output logic [16:0] level_out
);
    // Floating pins toggle so a stale level never passes
    logic [16:0] wander_reg = 17'h00000;
    always @(posedge clk_in) begin
        wander_reg <= ~wander_reg;
    end
    // The mux drive wins; the pull-up only holds a pin nobody drives
    always_comb begin
        for (int i = 0; i < 17; i++) begin
            if (drv_oe_in[i]) level_out[i] = drv_val_in[i];
            else if (ext_en_in[i]) level_out[i] = ext_val_in[i];
            else if (pull_in[i]) level_out[i] = 1'b1;
            else level_out[i] = wander_reg[i];
        end
    end
endmodule
`default_nettype wire

// ### verification/port_pin_function_mux_sva.sv
// Concurrent checks on the ports of the pin function multiplexer
`timescale 1ns/1ps
`default_nettype none

module port_pin_function_mux_sva (
    input wire logic MCLK_IN,
    input wire logic SYS_RST_IN,
    input wire logic [7:0] AVS_ADDRESS_IN,
    input wire logic AVS_READ_IN,
    input wire logic AVS_WRITE_IN,
    input wire logic [31:0] AVS_READDATA_OUT,
    input wire logic AVS_WAITREQUEST_OUT,
    input wire logic [16:0] PIN_OE_OUT,
    input wire logic [16:0] PIN_PULLUP_OUT,
    input wire logic [16:0] PIN_DRIVE_HIGH_OUT,
    input wire logic [22:0] PERIPH_PIN_OUT
);
    // ------------------------------------------------------------
    // One clock domain, so clock and reset are given once
    // ------------------------------------------------------------
    default clocking cb @(posedge MCLK_IN); endclocking
    default disable iff (SYS_RST_IN);

    a_drive_port_limit: assert property (PIN_DRIVE_HIGH_OUT[16:12] == 5'h00)
        else $error("drive raised on port without it");
    a_resetbit_no_extras: assert property (!PIN_PULLUP_OUT[16] && !PIN_DRIVE_HIGH_OUT[16])
        else $error("reset bit shows pull-up or drive");
    a_pullup_input_only: assert property ((PIN_PULLUP_OUT & PIN_OE_OUT) == 17'h00000)
        else $error("pull-up connected on a driven pin");
    a_wait_one_cycle: assert property ($rose(AVS_READ_IN || AVS_WRITE_IN) |=> !AVS_WAITREQUEST_OUT)
        else $error("no answer after one wait cycle");
    a_wait_single_low: assert property (!AVS_WAITREQUEST_OUT |=> AVS_WAITREQUEST_OUT)
        else $error("waitrequest low for more than one cycle");
    a_wait_has_cause: assert property (!AVS_WAITREQUEST_OUT |-> $past(AVS_READ_IN || AVS_WRITE_IN))
        else $error("waitrequest dropped without a request");
    a_unmapped_reads_zero: assert property ((AVS_READ_IN && AVS_WAITREQUEST_OUT &&
        AVS_ADDRESS_IN > 8'h73) |=> AVS_READDATA_OUT == 32'h00000000)
        else $error("unmapped read returned nonzero data");
    a_no_signal_zero: assert property (PERIPH_PIN_OUT[0] == 1'b0)
        else $error("code zero input driven");
    a_reset_quiet: assert property ($fell(SYS_RST_IN) |-> PIN_OE_OUT == 17'h00000 &&
        AVS_WAITREQUEST_OUT)
        else $error("pins or bus not quiet after reset");
endmodule

bind port_pin_function_mux port_pin_function_mux_sva sva_i (.*);
`default_nettype wire

// ### verification/port_pin_function_mux_tb_top.sv
// Self-checking bench for the port pin function multiplexer
`timescale 1ns/1ps
`default_nettype none

`define CHK_EQ(got, exp) begin checks++; if ((got) !== (exp)) begin err_count++; \
    $display("ERROR at %0t: value %h, expected %h", $time, (got), (exp)); end end

module port_pin_function_mux_tb_top;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdata = 32'h00000000;
    logic [31:0] rdata, rv;
    logic waitreq;
    logic [16:0] lvl, pin_out, pin_oe, pin_pull, pin_drv;
    logic [16:0] ext_en = 17'h00000;
    logic [16:0] ext_val = 17'h00000;
    logic [22:0] per_out = 23'h000000;
    logic [22:0] per_oe = 23'h000000;
    logic [22:0] per_pin;
    int err_count = 0;
    int checks = 0;
    int cycles = 0;

    port_pin_function_mux dut (.MCLK_IN(clk), .SYS_RST_IN(rst), .AVS_ADDRESS_IN(adr),
        .AVS_READ_IN(rd), .AVS_WRITE_IN(wr), .AVS_WRITEDATA_IN(wdata),
        .AVS_READDATA_OUT(rdata), .AVS_WAITREQUEST_OUT(waitreq), .PIN_IN(lvl),
        .PIN_OUT(pin_out), .PIN_OE_OUT(pin_oe), .PIN_PULLUP_OUT(pin_pull),
        .PIN_DRIVE_HIGH_OUT(pin_drv), .PERIPH_OUT_IN(per_out), .PERIPH_OE_IN(per_oe),
        .PERIPH_PIN_OUT(per_pin));
    pad_board_model pads (.clk_in(clk), .drv_val_in(pin_out), .drv_oe_in(pin_oe),
        .pull_in(pin_pull), .ext_en_in(ext_en), .ext_val_in(ext_val), .level_out(lvl));

    // ------------------------------------------------------------
    // Clock, hang guard and closing report
    // ------------------------------------------------------------
    initial begin
        forever #2.5 clk = ~clk;
    end
    // Run needs under a thousand cycles; wide margin
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_count++;
            summarize();
        end
    end
    task automatic summarize();
        $display("Comparisons %0d, mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Bus tasks: request held until waitrequest is sampled low
    // ------------------------------------------------------------
    task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        adr <= a;
        wdata <= d;
        wr <= 1'b1;
        do @(posedge clk); while (waitreq !== 1'b0);
        wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        adr <= a;
        rd <= 1'b1;
        do @(posedge clk); while (waitreq !== 1'b0);
        rv = rdata;
        rd <= 1'b0;
        `CHK_EQ(rv, exp)
    endtask
    // Covers the two-flop input path plus the registered outputs
    task automatic settle();
        repeat (5) @(posedge clk);
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        rd_chk(pin_mux_pkg::CONFIG_OFF, 32'h00000002);
        rd_chk(pin_mux_pkg::DIR_BASE_OFF, 32'h00000000);
        bus_wr(8'h74, 32'hffffffff);
        rd_chk(8'h74, 32'h00000000);
        rd_chk(8'h21, 32'h00000000);
        // Port 1 plain: low nibble out, high nibble pulled-up in
        bus_wr(pin_mux_pkg::DIR_BASE_OFF, 32'h0000000f);
        bus_wr(pin_mux_pkg::DATA_BASE_OFF, 32'h00000005);
        bus_wr(pin_mux_pkg::PULLUP_BASE_OFF, 32'h000000ff);
        bus_wr(pin_mux_pkg::DRIVE_BASE_OFF, 32'h000000f0);
        settle();
        `CHK_EQ(pin_oe[7:0], 8'h0f)
        `CHK_EQ(pin_out[3:0], 4'h5)
        `CHK_EQ(pin_pull[7:0], 8'hf0)
        `CHK_EQ(pin_drv[7:0], 8'hf0)
        rd_chk(pin_mux_pkg::DATA_BASE_OFF, 32'h000000f5);
        // Drive switching on port 4 and pull-up on port A do not exist
        bus_wr(pin_mux_pkg::DRIVE_BASE_OFF + 8'h08, 32'h000000ff);
        bus_wr(pin_mux_pkg::PULLUP_BASE_OFF + 8'h0c, 32'h00000001);
        rd_chk(pin_mux_pkg::DRIVE_BASE_OFF + 8'h08, 32'h00000000);
        rd_chk(pin_mux_pkg::PULLUP_BASE_OFF + 8'h0c, 32'h00000000);
        // Reset-shared bit stays off while hardware reset is in use
        bus_wr(pin_mux_pkg::DIR_BASE_OFF + 8'h0c, 32'h00000001);
        bus_wr(pin_mux_pkg::DATA_BASE_OFF + 8'h0c, 32'h00000001);
        settle();
        `CHK_EQ(pin_oe[16], 1'b0)
        // Crystal pins as outputs, then taken back by the oscillator
        bus_wr(pin_mux_pkg::DIR_BASE_OFF + 8'h08, 32'h000000c0);
        bus_wr(pin_mux_pkg::DATA_BASE_OFF + 8'h08, 32'h000000c0);
        bus_wr(pin_mux_pkg::CONFIG_OFF, 32'h00000000);
        settle();
        `CHK_EQ({pin_oe[16:14], pin_out[16:14]}, 6'h3f)
        bus_wr(pin_mux_pkg::CONFIG_OFF, 32'h00000001);
        settle();
        `CHK_EQ({pin_oe[16:14], pin_out[16:14]}, 6'h24)
        // Board pulls pin 7 low against the pull-up
        ext_en <= 17'h00080;
        settle();
        rd_chk(pin_mux_pkg::DATA_BASE_OFF, 32'h00000075);
        // Code 1 on port 1 bits 0-3 hands the pins to timer C outputs
        per_oe <= 23'h7fffff;
        bus_wr(pin_mux_pkg::MAP_P1_LOW_OFF, 32'h00000055);
        for (int k = 0; k < 2; k++) begin
            per_out[12:9] <= k ? 4'hc : 4'h3;
            settle();
            `CHK_EQ({pin_oe[3:0], pin_out[3:0]}, k ? 8'hf9 : 8'hf6)
        end
        // Code 2: key inputs driven by the board
        per_oe <= 23'h000000;
        ext_en <= 17'h0000f;
        ext_val <= 17'h00005;
        bus_wr(pin_mux_pkg::MAP_P1_LOW_OFF, 32'h000000aa);
        settle();
        `CHK_EQ(per_pin[6:3], 4'h5)
        bus_wr(pin_mux_pkg::MAP_P1_LOW_OFF, 32'h00000000);
        settle();
        `CHK_EQ(per_pin[6:3], 4'h0)
        // Expansion bit: code 4 on bit 4, pull-up drops
        per_oe[10] <= 1'b1;
        per_out[10] <= 1'b1;
        bus_wr(pin_mux_pkg::MAP_P1_EXT_OFF, 32'h00000001);
        settle();
        `CHK_EQ({pin_oe[4], pin_out[4], pin_pull[4]}, 3'h6)
        summarize();
    end
endmodule
`default_nettype wire
